// [logic/sdt_dead_time_pwm.sv]
/*
  dead-time generator and interrupt culling for a six-phase pwm timer:
  centre-aligned up/down counter, three basic phase waves, complementary
  outputs with dead time, culled crest/valley events and buffer transfer.
  assumes an avalon-mm master on ref_clk_in and gate drivers on the outs.
*/
`timescale 1ns/1ns
module sdt_dead_time_pwm
  import sdt_pkg::*;
(
  input  wire logic        ref_clk_in,          // 250 MHz count clock
  input  wire logic        rst_n_in,            // sync reset, active low
  input  wire logic [7:0]  avs_address_in,      // byte address
  input  wire logic        avs_read_in,         // read request
  input  wire logic        avs_write_in,        // write request
  input  wire logic [31:0] avs_writedata_in,    // write data
  input  wire logic [3:0]  avs_byteenable_in,   // byte lanes
  output logic      [31:0] avs_readdata_out,    // read data
  output logic             avs_waitrequest_out, // stall
  output logic      [2:0]  positive_phase_out,  // u,v,w positive
  output logic      [2:0]  negative_phase_out,  // u,v,w negative
  output logic             crest_event_out,     // culled crest pulse
  output logic             valley_event_out     // culled valley pulse
);
  // ==========================================================
  // state
  typedef struct packed {
    sdt_regs_type  regs;
    sdt_buf_type   bufr;
    sdt_phase_type ph;
    logic [15:0]   count;
    logic          down;
    logic          run_q;
    logic          pending;
    logic [4:0]    cull_cnt;
    logic          crest_irq;
    logic          valley_irq;
    logic          ack;
    logic [31:0]   rdata;
  } sdt_state_type;

  sdt_state_type st_q;
  sdt_state_type st_d;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // bus decode: one wait cycle, answer at the second edge
  logic        req;
  logic        wr_go;
  logic [31:0] rd_word;
  logic [31:0] wr_word;

  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~st_q.ack;
  assign wr_go               = avs_write_in & st_q.ack;
  assign avs_readdata_out    = st_q.rdata;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (avs_address_in)
      OFS_CTRL: begin
        rd_word[CTRL_RUN_BIT]     = st_q.regs.run_en;
        rd_word[CTRL_ANYTIME_BIT] = st_q.regs.anytime;
        rd_word[CTRL_XCULL_BIT]   = st_q.regs.xfer_cull;
        rd_word[CTRL_NARROW_BIT]  = st_q.regs.narrow;
      end
      OFS_CULL_CTRL: rd_word[6:0]  = st_q.regs.cull;
      OFS_CYCLE:     rd_word[15:0] = st_q.regs.cycle;
      OFS_DUTY_U:    rd_word[15:0] = st_q.regs.duty[0];
      OFS_DUTY_V:    rd_word[15:0] = st_q.regs.duty[1];
      OFS_DUTY_W:    rd_word[15:0] = st_q.regs.duty[2];
      OFS_DEAD_TIME: rd_word[9:0]  = st_q.regs.dead;
      OFS_STATUS: begin
        rd_word[15:0]                      = st_q.count;
        rd_word[STAT_DOWN_BIT]             = st_q.down;
        rd_word[STAT_POS_LSB +: 3]         = st_q.ph.pos;
        rd_word[STAT_NEG_LSB +: 3]         = st_q.ph.neg;
        rd_word[STAT_PEND_BIT]             = st_q.pending;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign wr_word = merge_be(rd_word, avs_writedata_in, avs_byteenable_in);
  // status is read-only: a write there is answered and dropped

  // ==========================================================
  // next state
  logic       crest;
  logic       valley;
  logic       cand;
  logic       emit;
  logic       xfer_time;
  logic [4:0] cull_n;

  always_comb begin
    logic       nw;
    logic       edge_seen;
    logic       start;
    st_d       = st_q;
    nw         = 1'b0;
    edge_seen  = 1'b0;
    start      = st_q.regs.run_en & ~st_q.run_q;
    cull_n     = st_q.bufr.cull[CULL_MSB_BIT:CULL_LSB_BIT];
    st_d.ack   = req & ~st_q.ack;
    st_d.run_q = st_q.regs.run_en;
    if (avs_read_in && !st_q.ack) begin
      st_d.rdata = rd_word;
    end

    // register writes
    if (wr_go) begin
      case (avs_address_in)
        OFS_CTRL: begin
          st_d.regs.run_en    = wr_word[CTRL_RUN_BIT];
          st_d.regs.anytime   = wr_word[CTRL_ANYTIME_BIT];
          st_d.regs.xfer_cull = wr_word[CTRL_XCULL_BIT];
          st_d.regs.narrow    = wr_word[CTRL_NARROW_BIT];
        end
        OFS_CULL_CTRL: st_d.regs.cull    = wr_word[6:0];
        OFS_CYCLE:     st_d.regs.cycle   = wr_word[15:0];
        OFS_DUTY_U:    st_d.regs.duty[0] = wr_word[15:0];
        OFS_DUTY_V:    st_d.regs.duty[1] = wr_word[15:0];
        OFS_DUTY_W:    st_d.regs.duty[2] = wr_word[15:0];
        OFS_DEAD_TIME: st_d.regs.dead    = wr_word[9:0];
        default: ;
      endcase
    end

    // up/down carrier counter
    // the cycle buffer, not the register, bounds the count
    crest  = st_q.regs.run_en & ~st_q.down &
             (st_q.count == st_q.bufr.cycle);
    valley = st_q.regs.run_en & st_q.down &
             (st_q.count == VALLEY_VAL);
    if (!st_q.regs.run_en) begin
      st_d.count = COUNT_RST;
      st_d.down  = 1'b0;
    end else if (st_q.down) begin
      st_d.count = st_q.count - 16'h0001;
      st_d.down  = ~valley;
    end else begin
      st_d.count = st_q.count + 16'h0001;
      st_d.down  = crest;
    end

    // interrupt culling over the enabled events
    cand = (crest  & st_q.bufr.cull[CULL_CREST_BIT]) |
           (valley & st_q.bufr.cull[CULL_VALLEY_BIT]);
    emit = cand & (st_q.cull_cnt == cull_n);
    if (!st_q.regs.run_en) begin
      st_d.cull_cnt = 5'h00;
    end else if (cand) begin
      st_d.cull_cnt = emit ? 5'h00 : st_q.cull_cnt + 5'h01;
    end
    st_d.crest_irq  = emit & crest;
    st_d.valley_irq = emit & valley;

    // buffer transfer
    xfer_time = st_q.regs.xfer_cull ? emit : (crest | valley);
    if (st_q.regs.anytime) begin
      st_d.bufr.cycle = st_d.regs.cycle;
      st_d.bufr.duty  = st_d.regs.duty;
      st_d.bufr.cull  = st_d.regs.cull;
      st_d.pending    = 1'b0;
    end else begin
      if (xfer_time && st_q.pending) begin
        st_d.bufr.cycle = st_q.regs.cycle;
        st_d.bufr.duty  = st_q.regs.duty;
        st_d.bufr.cull  = st_q.regs.cull;
        st_d.pending    = 1'b0;
      end
      // a u write in the transfer cycle stays pending: set wins
      if (wr_go && avs_address_in == OFS_DUTY_U) begin
        st_d.pending = 1'b1;
      end
    end

    // basic phase waves and dead time, one counter per phase
    for (int p = 0; p < 3; p++) begin
      nw = st_q.ph.wave[p];
      if (!st_q.regs.run_en) begin
        nw = 1'b0;
      end else if (crest) begin
        // duty of cycle+1 matches at the crest and falling wins
        nw = (st_q.bufr.duty[p] != st_q.bufr.cycle + 16'h0001);
      end else if (valley) begin
        nw = (st_q.bufr.duty[p] == 16'h0000);
      end else if (!st_q.down && st_q.count == st_q.bufr.duty[p]) begin
        nw = 1'b1;
      end else if (st_q.down && st_q.count == st_q.bufr.duty[p]) begin
        nw = 1'b0;
      end
      st_d.ph.wave[p] = nw;
      edge_seen = nw ^ st_q.ph.wave[p];

      if (start || (edge_seen && !st_q.ph.busy[p])) begin
        // full dead time counted first, so the first pulse is short
        st_d.ph.busy[p]     = (st_q.regs.dead != DEAD_RST);
        st_d.ph.cnt_down[p] = 1'b0;
        st_d.ph.dt_cnt[p]   = 10'h000;
      end else if (edge_seen && !st_q.regs.narrow) begin
        st_d.ph.cnt_down[p] = 1'b0;
        st_d.ph.dt_cnt[p]   = 10'h000;
      end else if (edge_seen) begin
        // reverse: the side that lost its gap gets it back sooner
        st_d.ph.cnt_down[p] = ~st_q.ph.cnt_down[p];
      end else if (st_q.ph.busy[p] && st_q.ph.cnt_down[p]) begin
        // ends at zero: the regained gap equals the time the wave was away
        if (st_q.ph.dt_cnt[p] == 10'h000) begin
          st_d.ph.busy[p]   = 1'b0;
          st_d.ph.dt_cnt[p] = 10'h000;
        end else begin
          st_d.ph.dt_cnt[p] = st_q.ph.dt_cnt[p] - 10'h001;
        end
      end else if (st_q.ph.busy[p]) begin
        if (st_q.ph.dt_cnt[p] + 10'h001 >= st_q.regs.dead) begin
          st_d.ph.busy[p] = 1'b0;
        end else begin
          st_d.ph.dt_cnt[p] = st_q.ph.dt_cnt[p] + 10'h001;
        end
      end
      st_d.ph.pos[p] = st_q.regs.run_en & nw & ~st_d.ph.busy[p];
      st_d.ph.neg[p] = st_q.regs.run_en & ~nw & ~st_d.ph.busy[p];
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_q            <= '0;
      st_q.regs.cycle <= CYCLE_RST;
      st_q.bufr.cycle <= CYCLE_RST;
      st_q.regs.dead  <= DEAD_RST;
      st_q.count      <= COUNT_RST;
    end else begin
      // the non-zero cycle reset values and the zero dead and count resets are spelled out above
      st_q <= st_d;
    end
  end

  assign positive_phase_out = st_q.ph.pos;
  assign negative_phase_out = st_q.ph.neg;
  assign crest_event_out    = st_q.crest_irq;
  assign valley_event_out   = st_q.valley_irq;

  // ==========================================================
  // assertions
  property p_no_overlap;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_q.ph.pos & st_q.ph.neg) == 3'b000;
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("positive and negative outputs high together");

  property p_crest_turn;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      crest |=> st_q.down && st_q.count == $past(st_q.count) + 16'h0001;
  endproperty
  a_crest_turn: assert property (p_crest_turn)
    else $error("counter did not turn down after crest");

  property p_valley_turn;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      valley |=> !st_q.down && st_q.count == 16'h0000;
  endproperty
  a_valley_turn: assert property (p_valley_turn)
    else $error("counter did not turn up after valley");

  property p_full_duty;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      valley && st_q.bufr.duty[1] == 16'h0000 |=> st_q.ph.wave[1];
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("zero duty did not hold wave high at valley");

  property p_zero_duty;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      crest && st_q.bufr.duty[2] == st_q.bufr.cycle + 16'h0001
      |=> !st_q.ph.wave[2];
  endproperty
  a_zero_duty: assert property (p_zero_duty)
    else $error("crest match did not keep wave low");

  property p_cull;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      (crest_event_out || valley_event_out) |->
        $past(st_q.cull_cnt) == $past(cull_n) && st_q.cull_cnt == 5'h00;
  endproperty
  a_cull: assert property (p_cull)
    else $error("interrupt emitted before cull count reached");

  property p_anytime;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      wr_go && st_q.regs.anytime && avs_address_in == OFS_DUTY_U
      |=> st_q.bufr.duty[0] == st_q.regs.duty[0];
  endproperty
  a_anytime: assert property (p_anytime)
    else $error("anytime write did not reach buffer");

  property p_restart;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      st_q.regs.run_en && st_q.ph.busy[0] && !st_q.regs.narrow &&
      (st_d.ph.wave[0] != st_q.ph.wave[0])
      |=> st_q.ph.dt_cnt[0] == 10'h000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("dead count not cleared on edge");

  property p_crest_only;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      crest_event_out |-> $past(st_q.bufr.cull[CULL_CREST_BIT]);
  endproperty
  a_crest_only: assert property (p_crest_only)
    else $error("crest interrupt while disabled");

  property p_bus_answer;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      req |-> ##[0:1] !avs_waitrequest_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus request not answered in one cycle");

  c_crest_irq:  cover property (@(posedge ref_clk_in) crest_event_out);
  c_valley_irq: cover property (@(posedge ref_clk_in) valley_event_out);
  c_narrow:     cover property (@(posedge ref_clk_in)
                  st_q.regs.narrow && st_q.ph.cnt_down[0]);
  c_transfer:   cover property (@(posedge ref_clk_in)
                  st_q.pending ##1 !st_q.pending);
endmodule

// [logic/sdt_pkg.sv]
/*
  package for the six-phase dead-time pwm block: register offsets,
  field positions, reset values and the state carriers.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package sdt_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CULL_CTRL = 8'h04;
  localparam logic [7:0] OFS_CYCLE     = 8'h08;
  localparam logic [7:0] OFS_DUTY_U    = 8'h0c;
  localparam logic [7:0] OFS_DUTY_V    = 8'h10;
  localparam logic [7:0] OFS_DUTY_W    = 8'h14;
  localparam logic [7:0] OFS_DEAD_TIME = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  // ==========================================================
  // control register fields
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_ANYTIME_BIT = 1;
  localparam int CTRL_XCULL_BIT   = 2;
  localparam int CTRL_NARROW_BIT  = 3;
  // cull control fields: count in 4:0, valley en 5, crest en 6
  localparam int CULL_LSB_BIT     = 0;
  localparam int CULL_MSB_BIT     = 4;
  localparam int CULL_VALLEY_BIT  = 5;
  localparam int CULL_CREST_BIT   = 6;
  // status fields
  localparam int STAT_DOWN_BIT    = 16;
  localparam int STAT_POS_LSB     = 17;
  localparam int STAT_NEG_LSB     = 20;
  localparam int STAT_PEND_BIT    = 23;
  // ==========================================================
  // reset values and fixed figures
  localparam logic [15:0] CYCLE_RST  = 16'hfffe;
  localparam logic [15:0] DUTY_RST   = 16'h0000;
  localparam logic [9:0]  DEAD_RST   = 10'h000;
  localparam logic [15:0] VALLEY_VAL = 16'h0001;
  localparam logic [15:0] COUNT_RST  = 16'h0000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        run_en;
    logic        anytime;
    logic        xfer_cull;
    logic        narrow;
    logic [6:0]  cull;
    logic [15:0] cycle;
    logic [2:0][15:0] duty;
    logic [9:0]  dead;
  } sdt_regs_type;

  typedef struct packed {
    logic [6:0]  cull;
    logic [15:0] cycle;
    logic [2:0][15:0] duty;
  } sdt_buf_type;

  typedef struct packed {
    logic [2:0]       wave;
    logic [2:0]       busy;
    logic [2:0]       cnt_down;
    logic [2:0][9:0]  dt_cnt;
    logic [2:0]       pos;
    logic [2:0]       neg;
  } sdt_phase_type;
endpackage

// [dv/sdt_gate_model.sv]
/*
  gate-driver model for the three inverter legs: counts high cycles of
  each positive and negative drive and latches any overlap.
  assumes the bench pulses clr_in to open a measuring window.
*/
`timescale 1ns/1ns
module sdt_gate_model (
  input  wire logic             clk_in,      // count clock
  input  wire logic             clr_in,      // window restart
  input  wire logic [2:0]       pos_in,      // positive drives
  input  wire logic [2:0]       neg_in,      // negative drives
  output logic      [2:0][15:0] pos_cnt_out, // positive high cycles
  output logic      [2:0][15:0] neg_cnt_out, // negative high cycles
  output logic                  overlap_out  // both sides on at once
);
  // ==========================================================
  // leg monitors
  // a real leg would short on overlap, so it is only recorded here
  always_ff @(posedge clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (clr_in) begin
        pos_cnt_out[i] <= 16'h0000;
        neg_cnt_out[i] <= 16'h0000;
      end else begin
        pos_cnt_out[i] <= pos_cnt_out[i] + {15'h0000, pos_in[i]};
        neg_cnt_out[i] <= neg_cnt_out[i] + {15'h0000, neg_in[i]};
      end
    end
    overlap_out <= clr_in ? 1'b0 : (overlap_out | (|(pos_in & neg_in)));
  end
endmodule

// [dv/six_phase_dead_time_pwm_bench.sv]
/*
  bench for the dead-time pwm block: register access over avalon-mm,
  leg widths and culled event counts over whole carrier periods.
  assumes the gate-driver model and one wait state per access.
*/
`timescale 1ns/1ns
module six_phase_dead_time_pwm_bench;
  import sdt_pkg::*;
  // ==========================================================
  // stimulus figures
  localparam logic [15:0] M  = 16'h0010;
  localparam logic [15:0] DU = 16'h0004;
  localparam int          DT = 3;
  localparam int          P  = 2 * (int'(M) + 1);
  localparam int          W  = 4 * P;
  logic              ref_clk_in;
  logic              rst_n_in;
  logic              clr;
  logic [7:0]        avs_address_in;
  logic              avs_read_in;
  logic              avs_write_in;
  logic [31:0]       avs_writedata_in;
  logic [31:0]       avs_readdata_out;
  logic              avs_waitrequest_out;
  logic [2:0]        pos;
  logic [2:0]        neg;
  logic              crest;
  logic              valley;
  logic [2:0][15:0]  pos_cnt;
  logic [2:0][15:0]  neg_cnt;
  logic              overlap;
  logic [7:0]        n_crest;
  logic [7:0]        n_valley;
  logic [31:0]       rd_q;
  int                miscompares;
  int                n_tests;

  sdt_dead_time_pwm uut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .positive_phase_out(pos), .negative_phase_out(neg),
    .crest_event_out(crest), .valley_event_out(valley));

  sdt_gate_model drv (
    .clk_in(ref_clk_in), .clr_in(clr), .pos_in(pos), .neg_in(neg),
    .pos_cnt_out(pos_cnt), .neg_cnt_out(neg_cnt), .overlap_out(overlap));

  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end

  always @(posedge ref_clk_in) begin
    n_crest  <= clr ? 8'h00 : n_crest + {7'h00, crest};
    n_valley <= clr ? 8'h00 : n_valley + {7'h00, valley};
  end

  // ==========================================================
  // bus, compare and window tasks
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50) begin
      miscompares++;
      conclude();
    end
    rd_q = avs_readdata_out;
    @(posedge ref_clk_in);
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic window(input int n);
    @(posedge ref_clk_in);
    clr <= 1'b1;
    @(posedge ref_clk_in);
    clr <= 1'b0;
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic wait_crest;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end while (crest !== 1'b1 && n < 200);
    if (n >= 200) begin
      miscompares++;
      conclude();
    end
  endtask

  task automatic leg(input int i, input int p, input int q);
    chk("positive width", {16'h0000, pos_cnt[i]}, 32'(p));
    chk("negative width", {16'h0000, neg_cnt[i]}, 32'(q));
    chk("overlap", {31'h0, overlap}, 32'h0);
  endtask

  task automatic events(input int c, input int v);
    chk("crest count", {24'h0, n_crest}, 32'(c));
    chk("valley count", {24'h0, n_valley}, 32'(v));
  endtask

  // ==========================================================
  // main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    rst_n_in = 1'b0;
    clr = 1'b0;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;

    bus(1'b0, OFS_CYCLE, 32'h0);
    chk("cycle reset", rd_q, {16'h0000, CYCLE_RST});
    bus(1'b0, OFS_DEAD_TIME, 32'h0);
    chk("dead reset", rd_q, {22'h0, DEAD_RST});
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped read", rd_q, 32'h0);
    chk("legs idle", {26'h0, pos, neg}, 32'h0);
    $display("test reset done");

    // anytime rewrite so settings land at once; cycle kept in range
    bus(1'b1, OFS_CTRL, 32'h2);
    bus(1'b1, OFS_CYCLE, {16'h0, M});
    bus(1'b1, OFS_DEAD_TIME, 32'(DT));
    bus(1'b1, OFS_DUTY_U, {16'h0, DU});
    bus(1'b1, OFS_DUTY_V, 32'h0);
    bus(1'b1, OFS_DUTY_W, {16'h0, M + 16'h0001});
    bus(1'b1, OFS_CULL_CTRL, 32'h60);
    bus(1'b1, OFS_CTRL, 32'h3);
    repeat (2 * P) @(posedge ref_clk_in);
    window(W);
    leg(0, 4 * (2 * (int'(M) + 1 - int'(DU)) - DT), 4 * (2 * int'(DU) - DT));
    leg(1, W, 0);
    leg(2, 0, W);
    events(4, 4);
    $display("test widths done");

    bus(1'b1, OFS_CULL_CTRL, 32'h42);
    window(6 * P);
    events(2, 0);
    bus(1'b1, OFS_CULL_CTRL, 32'h20);
    window(W);
    events(0, 4);
    $display("test culling done");

    // batch rewrite: w change waits for a u write, then a crest/valley
    bus(1'b1, OFS_CULL_CTRL, 32'h60);
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_DUTY_W, 32'h0);
    window(2 * P);
    leg(2, 0, 2 * P);
    bus(1'b1, OFS_DUTY_U, {16'h0, DU});
    repeat (P) @(posedge ref_clk_in);
    window(2 * P);
    leg(2, 2 * P, 0);
    leg(0, 2 * (2 * (int'(M) + 1 - int'(DU)) - DT), 2 * (2 * int'(DU) - DT));
    $display("test transfer done");

    // near 100%: u low for 2 clocks, shorter than the dead time
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b1, OFS_DUTY_U, 32'h1);
    repeat (P) @(posedge ref_clk_in);
    window(2 * P);
    leg(0, 2 * (2 * int'(M) - DT), 0);
    bus(1'b1, OFS_CTRL, 32'hb);
    repeat (P) @(posedge ref_clk_in);
    window(2 * P);
    leg(0, 2 * (2 * int'(M) - 2), 0);
    $display("test narrowing done");

    // intermittent batch: crest only, one skipped, transfer at emit only
    bus(1'b1, OFS_CULL_CTRL, 32'h41);
    bus(1'b1, OFS_CTRL, 32'h5);
    wait_crest();
    bus(1'b1, OFS_DUTY_W, {16'h0, M + 16'h0001});
    bus(1'b1, OFS_DUTY_U, 32'h1);
    repeat (P) @(posedge ref_clk_in);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("held past crest", {31'h0, rd_q[STAT_PEND_BIT]}, 32'h1);
    repeat (P) @(posedge ref_clk_in);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk("culled transfer", {31'h0, rd_q[STAT_PEND_BIT]}, 32'h0);
    window(2 * P);
    leg(2, 0, 2 * P);
    events(1, 0);
    $display("test transfer culling done");
    conclude();
  end
endmodule
